/* File: rtl/idf_decoder.sv */
// instruction format field decoder with an AXI4-Lite control/status port
// assumes a byte queue with valid/ready and an external opcode format lookup
// answered combinationally in the cycle the opcode byte is offered
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module idf_decoder (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             ce,
    input  wire logic             in_valid,
    input  wire logic [7:0]       in_byte,
    output logic                  in_ready,
    output logic [7:0]            lk_opc,
    output logic                  lk_two,
    input  wire logic             lk_has_modrm,
    input  wire logic [1:0]       lk_imm_sel,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output idf_pkg::idf_dec_t     out_dec,
    output idf_pkg::idf_gpr_t     out_gpr,
    input  wire logic [31:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [31:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    typedef enum logic [2:0] {
        ST_OPC, ST_OPC2, ST_MODRM, ST_SIB, ST_DISP, ST_IMM, ST_OUT
    } idf_state_t;

    idf_state_t        state_reg;
    idf_state_t        state_next;
    idf_pkg::idf_dec_t dec_reg;
    logic [2:0]        ctrl_reg;
    logic [15:0]       count_reg;
    logic [4:0]        last_len_reg;
    logic              pfx_op_reg;
    logic              pfx_ad_reg;
    logic [2:0]        pos_reg;
    logic [4:0]        pfx_cnt_reg;
    logic              bvalid_reg;
    logic              bad_w_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic              rbad_reg;

    // sizes: default from code segment bit, forced 16 outside protected mode and in V86 mode
    wire def_d    = ctrl_reg[idf_pkg::CTRL_PROT] & ~ctrl_reg[idf_pkg::CTRL_V86]
                    & ctrl_reg[idf_pkg::CTRL_CSD];
    // only the prefix position counts: a data byte equal to a prefix code must not toggle size
    wire is_opsz  = state_reg == ST_OPC && in_byte == idf_pkg::PFX_OPSIZE;
    wire is_adsz  = state_reg == ST_OPC && in_byte == idf_pkg::PFX_ADSIZE;
    // prefix flags are sticky ors, so their order cannot matter
    wire op32_now = def_d ^ (pfx_op_reg | is_opsz);
    wire ad32_now = def_d ^ (pfx_ad_reg | is_adsz);
    wire take     = ce & in_valid & in_ready;
    wire finish   = ce & out_valid & out_ready;

    // opcode byte fields
    wire       w_now   = in_byte[0];
    wire       d_now   = in_byte[1];
    wire       s_now   = in_byte[1];
    wire [5:0] bits_op = op32_now ? idf_pkg::BITS_32 : idf_pkg::BITS_16;
    wire [5:0] bits_now = w_now ? bits_op : idf_pkg::BITS_8;
    // byte writes to codes 100..111 hit the second byte lane
    wire [3:0] be_byte = in_byte[2] ? idf_pkg::BE_HIGH : idf_pkg::BE_LOW;
    wire [3:0] be_full = op32_now ? idf_pkg::BE_DWORD : idf_pkg::BE_WORD;
    wire [3:0] be_now  = w_now ? be_full : be_byte;
    wire [2:0] imm_now = (lk_imm_sel == idf_pkg::IMM_BYTE) ? 3'h1 :
                         (lk_imm_sel == idf_pkg::IMM_WORD) ? 3'h2 :
                         (lk_imm_sel == idf_pkg::IMM_FULL) ? (op32_now ? 3'h4 : 3'h2) :
                         3'h0;

    // mod r/m byte fields
    wire [1:0] m_mode = in_byte[7:6];
    wire [2:0] m_loc  = in_byte[2:0];
    wire       m_sib  = dec_reg.ad32 & (m_loc == idf_pkg::LOC_SIB)
                        & (m_mode != idf_pkg::MODE_REG);
    wire [2:0] dl16   = (m_mode == idf_pkg::MODE_DISP8) ? 3'h1 :
                        (m_mode == idf_pkg::MODE_DISPF) ? 3'h2 :
                        (m_mode == idf_pkg::MODE_NODISP && m_loc == idf_pkg::LOC_DIR16)
                        ? 3'h2 : 3'h0;
    wire [2:0] dl32   = (m_mode == idf_pkg::MODE_DISP8) ? 3'h1 :
                        (m_mode == idf_pkg::MODE_DISPF) ? 3'h4 :
                        (m_mode == idf_pkg::MODE_NODISP && m_loc == idf_pkg::LOC_DIRECT)
                        ? 3'h4 : 3'h0;
    wire [2:0] dl_m   = dec_reg.ad32 ? dl32 : dl16;
    // sib with no base and mode 00 carries a full displacement
    wire [2:0] dl_s   = (dec_reg.mode == idf_pkg::MODE_NODISP
                         && in_byte[2:0] == idf_pkg::LOC_DIRECT) ? 3'h4 : dec_reg.disp_len;

    wire [2:0] pos_inc = pos_reg + 3'h1;
    wire [4:0] len_inc = dec_reg.len + 5'h1;

    assign in_ready  = state_reg != ST_OUT;
    assign out_valid = state_reg == ST_OUT;
    assign out_dec   = dec_reg;
    assign out_gpr   = idf_pkg::idf_gpr_t'(dec_reg.has_modrm ? dec_reg.reg_f
                                                             : dec_reg.opc_reg);
    assign lk_opc    = in_byte;
    assign lk_two    = state_reg == ST_OPC2;

    // displacement comes before immediate; immediate ends the instruction
    function automatic idf_state_t after_addr(input logic [2:0] dl, input logic [2:0] il);
        if (dl != 3'h0)
            return ST_DISP;
        else if (il != 3'h0)
            return ST_IMM;
        return ST_OUT;
    endfunction

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OPC, ST_OPC2: begin
                if (state_reg == ST_OPC && (is_opsz || is_adsz))
                    state_next = ST_OPC;
                else if (state_reg == ST_OPC && in_byte == idf_pkg::OPC_ESCAPE)
                    state_next = ST_OPC2;
                else if (lk_has_modrm)
                    state_next = ST_MODRM;
                else
                    state_next = after_addr(3'h0, imm_now);
            end
            ST_MODRM: state_next = m_sib ? ST_SIB : after_addr(dl_m, dec_reg.imm_len);
            ST_SIB:   state_next = after_addr(dl_s, dec_reg.imm_len);
            ST_DISP:  state_next = (pos_inc != dec_reg.disp_len) ? ST_DISP :
                                   after_addr(3'h0, dec_reg.imm_len);
            ST_IMM:   state_next = (pos_inc != dec_reg.imm_len) ? ST_IMM : ST_OUT;
            ST_OUT:   state_next = ST_OUT;
            default:  state_next = ST_OPC;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            state_reg <= ST_OPC;
        else if (finish)
            state_reg <= ST_OPC;
        else if (take)
            state_reg <= state_next;
    end

    // per-instruction capture; everything clears when the result is taken
    always_ff @(posedge aclk) begin
        if (!aresetn || finish) begin
            dec_reg     <= '0;
            pfx_op_reg  <= 1'b0;
            pfx_ad_reg  <= 1'b0;
            pos_reg     <= 3'h0;
            pfx_cnt_reg <= 5'h0;
        end else if (take) begin
            dec_reg.len <= len_inc;
            dec_reg.op32 <= op32_now;
            dec_reg.ad32 <= ad32_now;
            pos_reg <= (state_next == state_reg) ? pos_inc : 3'h0;
            case (state_reg)
                ST_OPC, ST_OPC2: begin
                    if (state_reg == ST_OPC && (is_opsz || is_adsz)) begin
                        pfx_op_reg  <= pfx_op_reg | is_opsz;
                        pfx_ad_reg  <= pfx_ad_reg | is_adsz;
                        pfx_cnt_reg <= pfx_cnt_reg + 5'h1;
                    end else if (state_reg == ST_OPC && in_byte == idf_pkg::OPC_ESCAPE) begin
                        dec_reg.two <= 1'b1;
                    end else begin
                        dec_reg.opc             <= in_byte;
                        dec_reg.w               <= w_now;
                        dec_reg.d               <= d_now;
                        dec_reg.s               <= s_now;
                        dec_reg.opc_reg         <= in_byte[2:0];
                        dec_reg.seg_pick_narrow <= in_byte[4:3];
                        dec_reg.cond            <= in_byte[3:0];
                        dec_reg.has_modrm       <= lk_has_modrm;
                        dec_reg.imm_len         <= imm_now;
                        dec_reg.opnd_bits       <= bits_now;
                        dec_reg.dst_be          <= be_now;
                    end
                end
                ST_MODRM: begin
                    dec_reg.mode          <= m_mode;
                    dec_reg.reg_f         <= in_byte[5:3];
                    dec_reg.loc           <= m_loc;
                    dec_reg.seg_pick_wide <= in_byte[5:3];
                    dec_reg.has_sib       <= m_sib;
                    dec_reg.disp_len      <= dl_m;
                end
                ST_SIB: begin
                    dec_reg.scale    <= in_byte[7:6];
                    dec_reg.idx      <= in_byte[5:3];
                    dec_reg.base     <= in_byte[2:0];
                    dec_reg.disp_len <= dl_s;
                end
                ST_DISP: dec_reg.disp[{pos_reg[1:0], 3'h0} +: 8] <= in_byte;
                ST_IMM: begin
                    dec_reg.imm[{pos_reg[1:0], 3'h0} +: 8] <= in_byte;
                    // byte immediate with s set spreads its sign to the operand
                    if (dec_reg.s && dec_reg.imm_len == 3'h1)
                        dec_reg.imm_ext <= {{24{in_byte[7]}}, in_byte};
                    else
                        dec_reg.imm_ext[{pos_reg[1:0], 3'h0} +: 8] <= in_byte;
                end
                default: ;
            endcase
        end
    end

    // statistics for software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg    <= 16'h0;
            last_len_reg <= 5'h0;
        end else if (finish) begin
            count_reg    <= count_reg + 16'h1;
            last_len_reg <= dec_reg.len;
        end
    end

    // AXI4-Lite slave: write taken only when address and data are both present
    wire wr_go   = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
    wire wr_ctrl = s_axi_awaddr[3:0] == idf_pkg::ADDR_CTRL && s_axi_awaddr[31:4] == 28'h0;
    wire rd_go   = ce & s_axi_arvalid & ~rvalid_reg;
    wire rd_ctrl = s_axi_araddr[3:0] == idf_pkg::ADDR_CTRL && s_axi_araddr[31:4] == 28'h0;
    wire rd_stat = s_axi_araddr[3:0] == idf_pkg::ADDR_STAT && s_axi_araddr[31:4] == 28'h0;
    wire [31:0] rd_val = rd_ctrl ? {29'h0, ctrl_reg} :
                         rd_stat ? {11'h0, last_len_reg, count_reg} : 32'h0;

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bad_w_reg ? idf_pkg::RESP_SLVERR : idf_pkg::RESP_OKAY;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rbad_reg ? idf_pkg::RESP_SLVERR : idf_pkg::RESP_OKAY;

    // mode change mid-instruction only affects bytes still to come
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= idf_pkg::CTRL_RESET;
            bvalid_reg <= 1'b0;
            bad_w_reg  <= 1'b0;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bad_w_reg  <= ~wr_ctrl;
                if (wr_ctrl && s_axi_wstrb[0])
                    ctrl_reg <= s_axi_wdata[2:0];
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rbad_reg   <= 1'b0;
        end else if (ce) begin
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_val;
                rbad_reg   <= ~(rd_ctrl | rd_stat);
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sib_expected: assert property (ce && take && state_reg == ST_MODRM && dec_reg.ad32
        && in_byte[2:0] == 3'h4 && in_byte[7:6] != 2'h3 |=> state_reg == ST_SIB)
        else $error("sib byte not expected");
    a_no_sib_16: assert property (take && state_reg == ST_MODRM && !dec_reg.ad32
        |=> state_reg != ST_SIB)
        else $error("sib entered under 16-bit addressing");
    a_opsize_toggle: assert property (out_valid |-> dec_reg.op32 == (def_d ^ pfx_op_reg))
        else $error("operand size not default xor prefix");
    a_real_default: assert property (out_valid && !ctrl_reg[0]
        |-> dec_reg.op32 == pfx_op_reg && dec_reg.ad32 == pfx_ad_reg)
        else $error("real mode size not 16 by default");
    a_len_total: assert property (out_valid |-> dec_reg.len == pfx_cnt_reg
        + 5'(dec_reg.two) + 5'h1 + 5'(dec_reg.has_modrm) + 5'(dec_reg.has_sib)
        + 5'(dec_reg.disp_len) + 5'(dec_reg.imm_len))
        else $error("length mismatch");
    a_disp8_len: assert property (out_valid && dec_reg.has_modrm && dec_reg.mode == 2'h1
        |-> dec_reg.disp_len == 3'h1)
        else $error("mode 01 must carry one displacement byte");
    a_imm_last: assert property (ce && take && state_reg == ST_IMM
        |=> state_reg == ST_IMM || state_reg == ST_OUT)
        else $error("field after immediate");
    a_width_size: assert property (out_valid
        |-> dec_reg.opnd_bits == (!dec_reg.w ? 6'h08 : dec_reg.op32 ? 6'h20 : 6'h10))
        else $error("operand width wrong");
    a_narrow_mask: assert property (out_valid && !dec_reg.w
        |-> dec_reg.dst_be == 4'h1 || dec_reg.dst_be == 4'h2)
        else $error("byte write touches upper bits");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(dec_reg))
        else $error("result dropped before taken");
endmodule

/* File: rtl/idf_pkg.sv */
// shared types and constants for the instruction field decoder
// assumes one core clock, synchronous active-low reset
package idf_pkg;
    localparam logic [7:0]  PFX_OPSIZE  = 8'h66;
    localparam logic [7:0]  PFX_ADSIZE  = 8'h67;
    localparam logic [7:0]  OPC_ESCAPE  = 8'h0f;
    localparam logic [2:0]  LOC_SIB     = 3'h4;
    localparam logic [2:0]  LOC_DIRECT  = 3'h5;
    localparam logic [2:0]  LOC_DIR16   = 3'h6;
    localparam logic [1:0]  MODE_NODISP = 2'h0;
    localparam logic [1:0]  MODE_DISP8  = 2'h1;
    localparam logic [1:0]  MODE_DISPF  = 2'h2;
    localparam logic [1:0]  MODE_REG    = 2'h3;
    localparam logic [1:0]  IMM_NONE    = 2'h0;
    localparam logic [1:0]  IMM_BYTE    = 2'h1;
    localparam logic [1:0]  IMM_FULL    = 2'h2;
    localparam logic [1:0]  IMM_WORD    = 2'h3;
    localparam logic [5:0]  BITS_8      = 6'h08;
    localparam logic [5:0]  BITS_16     = 6'h10;
    localparam logic [5:0]  BITS_32     = 6'h20;
    localparam logic [3:0]  BE_LOW      = 4'h1;
    localparam logic [3:0]  BE_HIGH     = 4'h2;
    localparam logic [3:0]  BE_WORD     = 4'h3;
    localparam logic [3:0]  BE_DWORD    = 4'hf;
    // register map, byte addresses
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_STAT   = 4'h4;
    localparam int          CTRL_PROT   = 0;
    localparam int          CTRL_V86    = 1;
    localparam int          CTRL_CSD    = 2;
    localparam logic [2:0]  CTRL_RESET  = 3'h0;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        REG_ACC, REG_CNT, REG_DATA, REG_BASE, REG_SP, REG_BP, REG_SRC, REG_DST
    } idf_gpr_t;

    typedef struct packed {
        logic        op32;
        logic        ad32;
        logic        two;
        logic [7:0]  opc;
        logic        w;
        logic        d;
        logic        s;
        logic [2:0]  opc_reg;
        logic [1:0]  seg_pick_narrow;
        logic [3:0]  cond;
        logic        has_modrm;
        logic [1:0]  mode;
        logic [2:0]  reg_f;
        logic [2:0]  loc;
        logic [2:0]  seg_pick_wide;
        logic        has_sib;
        logic [1:0]  scale;
        logic [2:0]  idx;
        logic [2:0]  base;
        logic [2:0]  disp_len;
        logic [31:0] disp;
        logic [2:0]  imm_len;
        logic [31:0] imm;
        logic [31:0] imm_ext;
        logic [5:0]  opnd_bits;
        logic [3:0]  dst_be;
        logic [4:0]  len;
    } idf_dec_t;
endpackage

/* File: verif/idf_queue_model.sv */
// byte queue and opcode format table on the far side of the decoder
// assumes the bench fills it through push(); stall delays new offers only
module idf_queue_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       stall,
    input  wire logic       in_ready,
    output logic            in_valid,
    output logic [7:0]      in_byte,
    input  wire logic [7:0] lk_opc,
    input  wire logic       lk_two,
    output logic            lk_has_modrm,
    output logic [1:0]      lk_imm_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q[$];
    initial in_valid = 1'b0;
    initial in_byte = 8'h00;
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    // an offered byte holds until taken; idle data toggles so stale bytes never match
    always @(posedge aclk) begin
        if (!aresetn) begin
            in_valid <= 1'b0;
        end else if (!(in_valid && !in_ready)) begin
            if (in_valid) void'(q.pop_front());
            if (q.size() != 0 && !stall) begin
                in_valid <= 1'b1;
                in_byte  <= q[0];
            end else begin
                in_valid <= 1'b0;
                in_byte  <= ~in_byte;
            end
        end
    end
    // small format table: enough opcodes to reach every immediate kind
    always_comb begin
        lk_has_modrm = 1'b1;
        lk_imm_sel   = idf_pkg::IMM_NONE;
        if (lk_two || lk_opc == 8'h05 || lk_opc[7:3] == 5'h17) begin
            lk_has_modrm = 1'b0;
            lk_imm_sel   = idf_pkg::IMM_FULL;
        end else if (lk_opc == 8'h80 || lk_opc == 8'h83) begin
            lk_imm_sel = idf_pkg::IMM_BYTE;
        end else if (lk_opc == 8'hc2) begin
            lk_has_modrm = 1'b0;
            lk_imm_sel   = idf_pkg::IMM_WORD;
        end
    end
endmodule

/* File: verif/tb_idf_decoder.sv */
// self-checking bench: bytes through the queue model, control over AXI4-Lite
// assumes ce held high; results compared in order of issue
module tb_idf_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, out_ready = 1'b0, stall = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic in_valid, in_ready, lk_two, lk_has_modrm, out_valid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  in_byte, lk_opc;
    logic [1:0]  lk_imm_sel, s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, st = 32'hf9aaf4db, rr, rs;
    logic [4:0]  last_len = 5'h00;
    logic [15:0] n_instr = 16'h0000;
    logic [7:0]  bq[$];
    logic [80:0] eq[$];
    logic [42:0] fq[$];
    idf_pkg::idf_dec_t out_dec;
    idf_pkg::idf_gpr_t out_gpr;
    int failures = 0, check_count = 0;

    idf_decoder u_idf_decoder (.aclk, .aresetn, .ce(1'b1), .in_valid, .in_byte, .in_ready,
        .lk_opc, .lk_two, .lk_has_modrm, .lk_imm_sel, .out_valid, .out_ready, .out_dec,
        .out_gpr, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    idf_queue_model u_idf_queue_model (.aclk, .aresetn, .stall, .in_ready, .in_valid,
        .in_byte, .lk_opc, .lk_two, .lk_has_modrm, .lk_imm_sel);

    initial forever #50 aclk = ~aclk;

    function logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    task check(input logic [80:0] s, input logic [80:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // bytes of bq go to the queue, the expected decode to eq, small fields to fq
    task run(input logic o, a, sb, input logic [4:0] ln, input logic [2:0] dl, il, g,
             input logic [31:0] dp, im);
        int k;
        logic tw;
        logic [7:0] mb, sbb;
        logic [5:0] nb;
        k = 0;
        while (bq[k] == idf_pkg::PFX_OPSIZE || bq[k] == idf_pkg::PFX_ADSIZE) k++;
        tw = bq[k] == idf_pkg::OPC_ESCAPE;
        k = k + int'(tw);
        // a byte left over once the other fields are counted is the mod r/m byte
        mb = (ln != 5'(k + 1 + sb + dl + il)) ? bq[k + 1] : 8'h00;
        sbb = sb ? bq[k + 2] : 8'h00;
        nb = !bq[k][0] ? idf_pkg::BITS_8 : o ? idf_pkg::BITS_32 : idf_pkg::BITS_16;
        foreach (bq[i]) u_idf_queue_model.push(bq[i]);
        eq.push_back({o, a, sb, ln, dl, il, g, dp, im});
        fq.push_back({tw, bq[k], bq[k][0], bq[k][1], bq[k][1], bq[k][3:0], bq[k][4:3], nb,
                      mb[7:6], mb[5:3], mb[2:0], mb[5:3], sbb});
        n_instr++;
        last_len = ln;
    endtask
    // size is sampled per byte, so control changes wait for an empty pipe
    task idle();
        while (eq.size() != 0) @(posedge aclk);
    endtask
    task axi_wr(input logic [31:0] a, d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(81'(s_axi_bresp), 81'(er));
    endtask
    task axi_rd(input logic [31:0] a, d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        check(81'({s_axi_rdata, s_axi_rresp}), 81'({d, er}));
    endtask

    // consumer stalls and queue gaps at random
    always @(posedge aclk) begin
        rs = rnd();
        out_ready <= rs[0] | rs[1];
        stall <= rs[2] & rs[3];
    end
    always @(posedge aclk) begin
        if (aresetn && out_valid && out_ready) begin
            check({out_dec.op32, out_dec.ad32, out_dec.has_sib, out_dec.len, out_dec.disp_len,
                   out_dec.imm_len, 3'(out_gpr), out_dec.disp, out_dec.imm_ext},
                  eq.size() != 0 ? eq.pop_front() : '1);
            check(81'({out_dec.two, out_dec.opc, out_dec.w, out_dec.d, out_dec.s, out_dec.cond,
                       out_dec.seg_pick_narrow, out_dec.opnd_bits, out_dec.mode, out_dec.reg_f,
                       out_dec.loc, out_dec.seg_pick_wide, out_dec.scale, out_dec.idx,
                       out_dec.base}),
                  fq.size() != 0 ? 81'(fq.pop_front()) : '1);
        end
    end

    initial begin
        #(5000 * 100);
        failures++;
        results();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        bq = '{8'h66, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12};
        run(1'b1, 1'b0, 1'b0, 5'h06, 3'h0, 3'h4, 3'h5, 32'h0, 32'h12345678);
        bq = '{8'h66, 8'h67, 8'h89, 8'h84, 8'h88, 8'h44, 8'h33, 8'h22, 8'h11};
        run(1'b1, 1'b1, 1'b1, 5'h09, 3'h4, 3'h0, 3'h0, 32'h11223344, 32'h0);
        bq = '{8'h67, 8'h66, 8'h89, 8'h84, 8'h88, 8'h44, 8'h33, 8'h22, 8'h11};
        run(1'b1, 1'b1, 1'b1, 5'h09, 3'h4, 3'h0, 3'h0, 32'h11223344, 32'h0);
        bq = '{8'h89, 8'hc8};
        run(1'b0, 1'b0, 1'b0, 5'h02, 3'h0, 3'h0, 3'h1, 32'h0, 32'h0);
        bq = '{8'h89, 8'h44, 8'hd8};
        run(1'b0, 1'b0, 1'b0, 5'h03, 3'h1, 3'h0, 3'h0, 32'hd8, 32'h0);
        bq = '{8'h67, 8'h89, 8'h44, 8'h24, 8'hd8};
        run(1'b0, 1'b1, 1'b1, 5'h05, 3'h1, 3'h0, 3'h0, 32'hd8, 32'h0);
        bq = '{8'h89, 8'h06, 8'h34, 8'h12};
        run(1'b0, 1'b0, 1'b0, 5'h04, 3'h2, 3'h0, 3'h0, 32'h1234, 32'h0);
        bq = '{8'h80, 8'hc1, 8'hf0};
        run(1'b0, 1'b0, 1'b0, 5'h03, 3'h0, 3'h1, 3'h0, 32'h0, 32'hf0);
        bq = '{8'h83, 8'hc1, 8'hf0};
        run(1'b0, 1'b0, 1'b0, 5'h03, 3'h0, 3'h1, 3'h0, 32'h0, 32'hfffffff0);
        bq = '{8'h0f, 8'h84, 8'h34, 8'h12};
        run(1'b0, 1'b0, 1'b0, 5'h04, 3'h0, 3'h2, 3'h4, 32'h0, 32'h1234);
        idle();
        axi_rd(32'h0, 32'h0, idf_pkg::RESP_OKAY);
        axi_wr(32'h0, 32'h5, idf_pkg::RESP_OKAY);
        bq = '{8'h05, 8'h78, 8'h56, 8'h34, 8'h12};
        run(1'b1, 1'b1, 1'b0, 5'h05, 3'h0, 3'h4, 3'h5, 32'h0, 32'h12345678);
        bq = '{8'h66, 8'h05, 8'h34, 8'h12};
        run(1'b0, 1'b1, 1'b0, 5'h04, 3'h0, 3'h2, 3'h5, 32'h0, 32'h1234);
        bq = '{8'h89, 8'h04, 8'h88};
        run(1'b1, 1'b1, 1'b1, 5'h03, 3'h0, 3'h0, 3'h0, 32'h0, 32'h0);
        bq = '{8'hc2, 8'h34, 8'h12};
        run(1'b1, 1'b1, 1'b0, 5'h03, 3'h0, 3'h2, 3'h2, 32'h0, 32'h1234);
        idle();
        axi_wr(32'h0, 32'h7, idf_pkg::RESP_OKAY);
        axi_rd(32'h0, 32'h7, idf_pkg::RESP_OKAY);
        bq = '{8'h05, 8'h34, 8'h12};
        run(1'b0, 1'b0, 1'b0, 5'h03, 3'h0, 3'h2, 3'h5, 32'h0, 32'h1234);
        idle();
        axi_wr(32'h0, 32'h0, idf_pkg::RESP_OKAY);
        for (int i = 0; i < 20; i++) begin
            rr = rnd();
            bq = '{{5'h17, rr[2:0]}, rr[15:8], rr[23:16]};
            run(1'b0, 1'b0, 1'b0, 5'h03, 3'h0, 3'h2, rr[2:0], 32'h0,
                {16'h0, rr[23:16], rr[15:8]});
        end
        idle();
        axi_wr(32'h8, 32'h1, idf_pkg::RESP_SLVERR);
        axi_rd(32'h8, 32'h0, idf_pkg::RESP_SLVERR);
        axi_rd(32'h4, {11'h0, last_len, n_instr}, idf_pkg::RESP_OKAY);
        results();
    end
endmodule
